// file: rtl/rssc_pkg.sv
package rssc_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS  = 10;
   localparam int POWERUP_DELAY_TIMER_TIME_MS   = 64;
   localparam int POWERUP_DELAY_TIMER_CYC       = (POWERUP_DELAY_TIMER_TIME_MS * 1000000 + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
   localparam int EXEC_DELAY_CYC = 10;
   localparam int FILT_LEN_DEF   = 4;
   // ==========================================================
   // Register map (word index on the plain port)
   localparam logic [2:0] REG_BOR_CTL = 3'h0;
   localparam logic [2:0] REG_CAUSE   = 3'h1;
   localparam logic [2:0] REG_STATUS  = 3'h2;
   localparam logic [2:0] REG_PIN_CTL = 3'h3;
   // ==========================================================
   // Field positions
   localparam int SOFTWARE_MONITOR_ENABLE_BIT = 7;
   localparam int RSVD_BIT   = 6;
   localparam int RDY_BIT    = 0;
   localparam int C_OVF      = 7;
   localparam int C_UNF      = 6;
   localparam int C_WDT      = 4;
   localparam int C_PIN      = 3;
   localparam int C_RI       = 2;
   localparam int C_POR      = 1;
   localparam int C_BOR      = 0;
   localparam int TO_BIT     = 4;
   localparam int PD_BIT     = 3;
   localparam int PULL_BIT   = 0;
   localparam int GPIO_BIT   = 1;
   // ==========================================================
   // Reset values and vectors
   localparam logic [7:0]  CAUSE_POR   = 8'h1C;
   localparam logic [7:0]  CAUSE_WMASK = 8'hDF;
   localparam logic [7:0]  BORCTL_RST  = 8'h80;
   localparam logic [15:0] RESET_VEC   = 16'h0000;
   localparam logic [15:0] INT_VEC     = 16'h0004;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      MODE_OFF     = 2'b00,
      MODE_SW      = 2'b01,
      MODE_NOSLEEP = 2'b10,
      MODE_ON      = 2'b11
   } rssc_mode_t;
   typedef enum logic [2:0] {
      ST_HOLD = 3'b000,
      ST_POWERUP_DELAY_TIMER = 3'b001,
      ST_WAIT = 3'b010,
      ST_DLY  = 3'b011,
      ST_RUN  = 3'b100
   } rssc_state_t;
endpackage

// file: rtl/rssc_top.sv
`timescale 1ns/100ps
module rssc_top
   import rssc_pkg::*;
#(
   parameter int POWERUP_DELAY_TIMER_CYCLES = rssc_pkg::POWERUP_DELAY_TIMER_CYC,
   parameter int FILT_LEN    = rssc_pkg::FILT_LEN_DEF
) (
   // Clock and power-on reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Configuration word bits
   input  wire rssc_pkg::rssc_mode_t supply_monitor_mode_field,
   input  wire logic        low_power_monitor_disable_cfg,
   input  wire logic        reset_pin_enable_cfg,
   input  wire logic        low_voltage_programming_cfg,
   input  wire logic        stack_reset_enable_cfg,
   input  wire logic        powerup_delay_enable_n_cfg,
   input  wire logic        osc_needs_startup_cfg,
   // Supply monitors and oscillator
   input  wire logic        brownout_trip,
   input  wire logic        low_power_supply_monitor_trip,
   input  wire logic        oscillator_startup_done,
   output logic             brownout_enable_o,
   // Core events
   input  wire logic        sleep_active,
   input  wire logic        sleep_enter,
   input  wire logic        watchdog_timeout,
   input  wire logic        watchdog_clear_instruction,
   input  wire logic        reset_instruction,
   input  wire logic        stack_overflow,
   input  wire logic        stack_underflow,
   input  wire logic        programming_exit,
   input  wire logic        interrupt_wake,
   input  wire logic        global_interrupt_enable,
   // Core control
   output logic             core_reset_n_o,
   output logic             vector_load_o,
   output logic             push_return_o,
   output logic [15:0]      vector_o,
   // External reset pin
   input  wire logic        external_reset_pin_i,
   output logic             external_reset_pin_o,
   output logic             external_reset_pin_oe,
   output logic             pin_pullup_en_o,
   output logic             pin_gpio_value_o,
   // Register port
   input  wire logic [2:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata
);
   import rssc_pkg::*;

   initial begin
      if (POWERUP_DELAY_TIMER_CYCLES < 1 || FILT_LEN < 2 || FILT_LEN > 255) begin
         $error("rssc_top: unsupported parameter value");
      end
   end

   // ==========================================================
   // Declarations
   logic              pin_s1_reg;
   logic              pin_s2_reg;
   logic              filt_high_reg;
   logic [7:0]        filt_cnt_reg;
   logic [31:0]       powerup_delay_timer_cnt_reg;
   logic [3:0]        dly_cnt_reg;
   logic              powerup_delay_timer_done_reg;
   logic              power_seq_reg;
   logic              wake_pend_reg;
   logic              software_monitor_enable_reg;
   logic              rsvd_reg;
   logic              ready_reg;
   logic              pullup_sw_reg;
   logic [7:0]        cause_reg;
   logic              to_n_reg;
   logic              pd_n_reg;
   rssc_state_t       state_reg;
   logic              pin_en;
   logic              pin_req;
   logic              bor_active;
   logic              lp_req;
   logic              brown_req;
   logic              lp_por;
   logic              wdt_rst;
   logic              stk_rst;
   logic              pulse_req;
   logic              any_req;
   logic              osc_ok;
   logic              start_ok;
   logic              wr_cause;

   // ==========================================================
   // Reset sources
   assign pin_en     = low_voltage_programming_cfg | reset_pin_enable_cfg;
   assign pin_req    = pin_en & ~filt_high_reg;
   always_comb begin
      unique case (supply_monitor_mode_field)
         MODE_ON:      bor_active = 1'b1;
         MODE_NOSLEEP: bor_active = ~sleep_active;
         MODE_SW:      bor_active = software_monitor_enable_reg;
         MODE_OFF:     bor_active = 1'b0;
      endcase
   end
   // Erased configuration reads 1, which keeps the low-power monitor off
   assign lp_req     = ~low_power_monitor_disable_cfg
                       & low_power_supply_monitor_trip;
   assign brown_req  = (bor_active & brownout_trip) | lp_req;
   assign lp_por     = lp_req & (supply_monitor_mode_field == MODE_NOSLEEP);
   assign wdt_rst    = watchdog_timeout & ~sleep_active;
   assign stk_rst    = stack_reset_enable_cfg
                       & (stack_overflow | stack_underflow);
   assign pulse_req  = wdt_rst | reset_instruction | stk_rst
                       | programming_exit;
   assign any_req    = brown_req | pin_req | pulse_req;
   assign osc_ok     = ~osc_needs_startup_cfg | oscillator_startup_done;
   assign start_ok   = ~pin_req & osc_ok
                       & (powerup_delay_timer_done_reg | ~power_seq_reg);
   assign wr_cause   = reg_wr & (reg_addr == REG_CAUSE);

   // ==========================================================
   // Pin synchroniser and glitch filter
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_s1_reg <= 1'b1;
         pin_s2_reg <= 1'b1;
      end else begin
         pin_s1_reg <= external_reset_pin_i;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   // A level must persist FILT_LEN samples before the filtered pin follows
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         filt_high_reg <= 1'b1;
         filt_cnt_reg  <= 8'h00;
      end else if (pin_s2_reg == filt_high_reg) begin
         filt_cnt_reg  <= 8'h00;
      end else if (filt_cnt_reg == 8'(FILT_LEN - 1)) begin
         filt_high_reg <= pin_s2_reg;
         filt_cnt_reg  <= 8'h00;
      end else begin
         filt_cnt_reg  <= filt_cnt_reg + 8'h01;
      end
   end

   // Never drive the pin; weak pull-up follows software when pin is GPIO
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         external_reset_pin_o  <= 1'b0;
         external_reset_pin_oe <= 1'b0;
         pin_pullup_en_o       <= 1'b1;
         pin_gpio_value_o      <= 1'b1;
      end else begin
         external_reset_pin_o  <= 1'b0;
         external_reset_pin_oe <= 1'b0;
         pin_pullup_en_o       <= pin_en | pullup_sw_reg;
         pin_gpio_value_o      <= pin_en ? 1'b1 : pin_s2_reg;
      end
   end

   // ==========================================================
   // Start-up sequencer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg     <= ST_HOLD;
         power_seq_reg <= 1'b1;
         powerup_delay_timer_cnt_reg  <= 32'h0000_0000;
         powerup_delay_timer_done_reg <= 1'b0;
         dly_cnt_reg   <= 4'h0;
      end else if (brown_req) begin
         state_reg     <= ST_HOLD;
         power_seq_reg <= 1'b1;
         powerup_delay_timer_done_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_HOLD: begin
               // Timer waits for both power-on and brown-out to release
               if (!pulse_req) begin
                  powerup_delay_timer_cnt_reg <= 32'h0000_0000;
                  if (power_seq_reg && !powerup_delay_enable_n_cfg) begin
                     state_reg <= ST_POWERUP_DELAY_TIMER;
                  end else begin
                     powerup_delay_timer_done_reg <= 1'b1;
                     state_reg     <= ST_WAIT;
                  end
               end
            end
            ST_POWERUP_DELAY_TIMER: begin
               // Runs regardless of the reset pin
               if (powerup_delay_timer_cnt_reg == 32'(POWERUP_DELAY_TIMER_CYCLES - 1)) begin
                  powerup_delay_timer_done_reg <= 1'b1;
                  state_reg     <= ST_WAIT;
               end else begin
                  powerup_delay_timer_cnt_reg  <= powerup_delay_timer_cnt_reg + 32'h0000_0001;
               end
            end
            ST_WAIT: begin
               if (start_ok) begin
                  dly_cnt_reg <= 4'(EXEC_DELAY_CYC - 1);
                  state_reg   <= ST_DLY;
               end
            end
            ST_DLY: begin
               if (any_req) begin
                  state_reg <= ST_HOLD;
               end else if (dly_cnt_reg == 4'h0) begin
                  state_reg     <= ST_RUN;
                  power_seq_reg <= 1'b0;
               end else begin
                  dly_cnt_reg <= dly_cnt_reg - 4'h1;
               end
            end
            ST_RUN: begin
               if (any_req) begin
                  state_reg <= ST_HOLD;
               end
            end
            default: state_reg <= ST_HOLD;
         endcase
      end
   end

   // Release is synchronous; assertion lags the request by one edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         core_reset_n_o <= 1'b0;
      end else begin
         core_reset_n_o <= !any_req && ((state_reg == ST_RUN)
                           || (state_reg == ST_DLY && dly_cnt_reg == 4'h0));
      end
   end

   // ==========================================================
   // Vector load and interrupt wake
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wake_pend_reg <= 1'b0;
         vector_load_o <= 1'b0;
         push_return_o <= 1'b0;
         vector_o      <= RESET_VEC;
      end else begin
         wake_pend_reg <= interrupt_wake & sleep_active & global_interrupt_enable
                          & (state_reg == ST_RUN) & ~any_req;
         vector_load_o <= 1'b0;
         push_return_o <= 1'b0;
         if (state_reg == ST_DLY && dly_cnt_reg == 4'h0 && !any_req) begin
            vector_load_o <= 1'b1;
            vector_o      <= RESET_VEC;
         end else if (wake_pend_reg) begin
            // One instruction has run since the wake; now vector
            vector_load_o <= 1'b1;
            push_return_o <= 1'b1;
            vector_o      <= INT_VEC;
         end
      end
   end

   // ==========================================================
   // Cause flags: software write first, hardware events win
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cause_reg <= CAUSE_POR;
      end else begin
         if (wr_cause) begin
            cause_reg <= reg_wdata & CAUSE_WMASK;
         end
         if (lp_por) begin
            cause_reg <= CAUSE_POR;
         end else if (brown_req) begin
            cause_reg <= {2'b00, 1'b0, 3'b111,
                          (wr_cause ? reg_wdata[C_POR] : cause_reg[C_POR]),
                          1'b0};
         end else begin
            if (wdt_rst) cause_reg[C_WDT] <= 1'b0;
            if (pin_req && core_reset_n_o) cause_reg[C_PIN] <= 1'b0;
            if (reset_instruction) cause_reg[C_RI] <= 1'b0;
            if (stk_rst && stack_overflow) cause_reg[C_OVF] <= 1'b1;
            if (stk_rst && stack_underflow) cause_reg[C_UNF] <= 1'b1;
         end
      end
   end

   // Timeout and power-down status
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         to_n_reg <= 1'b1;
         pd_n_reg <= 1'b1;
      end else if (lp_por || brown_req) begin
         to_n_reg <= 1'b1;
         pd_n_reg <= 1'b1;
      end else if (watchdog_timeout) begin
         to_n_reg <= 1'b0;
         if (sleep_active) pd_n_reg <= 1'b0;
      end else if (watchdog_clear_instruction) begin
         to_n_reg <= 1'b1;
         pd_n_reg <= 1'b1;
      end else if (sleep_enter || (sleep_active && (interrupt_wake || pin_req))) begin
         to_n_reg <= 1'b1;
         pd_n_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Brown-out control and pin control registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         software_monitor_enable_reg    <= BORCTL_RST[SOFTWARE_MONITOR_ENABLE_BIT];
         rsvd_reg      <= BORCTL_RST[RSVD_BIT];
         ready_reg     <= 1'b0;
         pullup_sw_reg <= 1'b1;
      end else begin
         ready_reg <= bor_active;
         if (brown_req) begin
            software_monitor_enable_reg <= BORCTL_RST[SOFTWARE_MONITOR_ENABLE_BIT];
            rsvd_reg   <= BORCTL_RST[RSVD_BIT];
         end else if (reg_wr && reg_addr == REG_BOR_CTL) begin
            software_monitor_enable_reg <= reg_wdata[SOFTWARE_MONITOR_ENABLE_BIT];
            rsvd_reg   <= reg_wdata[RSVD_BIT];
         end
         if (reg_wr && reg_addr == REG_PIN_CTL) begin
            pullup_sw_reg <= reg_wdata[PULL_BIT];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         brownout_enable_o <= 1'b0;
      end else begin
         brownout_enable_o <= bor_active;
      end
   end

   // Read data stands one cycle after the strobe, zero otherwise
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            unique case (reg_addr)
               REG_BOR_CTL: reg_rdata <= {software_monitor_enable_reg, rsvd_reg, 5'b00000, ready_reg};
               REG_CAUSE:   reg_rdata <= cause_reg;
               REG_STATUS:  reg_rdata <= {3'b000, to_n_reg, pd_n_reg, 3'b000};
               REG_PIN_CTL: reg_rdata <= {6'b000000, pin_gpio_value_o, pullup_sw_reg};
               default:     reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_pin_not_driven: assert property (!external_reset_pin_oe)
      else $error("reset pin output enabled");
   chk_brown_flag_clear: assert property (brown_req |=> !cause_reg[C_BOR])
      else $error("brown-out flag not cleared");
   chk_pin_gate_cfg: assert property (pin_req |-> (reset_pin_enable_cfg
      || low_voltage_programming_cfg))
      else $error("pin reset while pin disabled");
   chk_pin_holds_rst: assert property (pin_req |=> !core_reset_n_o)
      else $error("core released with pin low");
   chk_glitch_ignored: assert property (filt_high_reg && pin_s2_reg ##1 !pin_s2_reg
      ##1 pin_s2_reg |-> filt_high_reg)
      else $error("one-sample glitch reached filter");
   chk_wdt_flags: assert property (wdt_rst && !brown_req
      |=> !cause_reg[C_WDT] && !to_n_reg)
      else $error("watchdog flags not updated");
   chk_ri_flag: assert property (reset_instruction && !brown_req
      |=> !cause_reg[C_RI] && !core_reset_n_o)
      else $error("reset instruction flag not cleared");
   chk_stack_reset: assert property (stack_overflow && stack_reset_enable_cfg
      && !brown_req && !lp_por |=> cause_reg[C_OVF] && !core_reset_n_o)
      else $error("stack overflow reset missing");
   chk_powerup_delay_timer_holds: assert property (state_reg == ST_POWERUP_DELAY_TIMER |=> !core_reset_n_o)
      else $error("core released during power-up timer");
   chk_exec_delay: assert property ($rose(core_reset_n_o) |->
      $past(state_reg) == ST_DLY && $past(dly_cnt_reg) == 4'h0)
      else $error("release not at end of start delay");
   chk_int_vector: assert property (interrupt_wake && sleep_active
      && global_interrupt_enable && state_reg == ST_RUN && !any_req
      |-> ##2 vector_load_o && push_return_o && vector_o == INT_VEC)
      else $error("interrupt vector not loaded");
   chk_ready_bit: assert property (rst_n |=> ready_reg == $past(bor_active))
      else $error("ready bit does not follow circuit");

   cov_pin_reset: cover property (pin_req ##[1:100] $rose(core_reset_n_o));
   cov_wdt_reset: cover property (wdt_rst ##1 !core_reset_n_o);
   cov_int_wake: cover property (wake_pend_reg ##1 vector_load_o);
   cov_brown: cover property (brown_req ##1 state_reg == ST_HOLD);

endmodule // rssc_top

// file: sim/rssc_far_model.sv
`timescale 1ns/100ps
// ==========================================================
// Far side: reset pin with weak pull-up, supply monitors, oscillator
module rssc_far_model #(
   parameter int OSC_CYC = 8
) (
   // Clock and power-on
   input  wire logic clk,
   input  wire logic rst_n,
   // Bench controls
   input  wire logic hold_low,
   input  wire logic sag,
   input  wire logic lp_sag,
   // Device side
   input  wire logic pin_o,
   input  wire logic pin_oe,
   output logic      pin,
   output logic      trip,
   output logic      lp_trip,
   output logic      osc_done
);
   int cnt;
   // Line floats to the pull-up unless someone sinks it
   assign pin = (hold_low | (pin_oe & ~pin_o)) ? 1'b0 : 1'b1;
   assign trip = sag;
   assign lp_trip = lp_sag;
   // Start-up timer restarts with every power-on
   always_ff @(posedge clk) begin
      if (!rst_n) cnt <= 0;
      else if (cnt < OSC_CYC) cnt <= cnt + 1;
   end
   assign osc_done = (cnt >= OSC_CYC);
endmodule // rssc_far_model

// file: sim/reset_source_and_startup_control_test.sv
`timescale 1ns/100ps
module reset_source_and_startup_control_test;
   import rssc_pkg::*;
   localparam int POWERUP_DELAY_TIMER = 20;
   logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, hold_low = 0, sag = 0, lp_sag = 0;
   rssc_mode_t supply_monitor_mode_field = MODE_ON;
   logic low_power_monitor_disable_cfg = 0, reset_pin_enable_cfg = 1, sleep_active = 0;
   logic low_voltage_programming_cfg = 0, stack_reset_enable_cfg = 0, sleep_enter = 0;
   logic powerup_delay_enable_n_cfg = 0, osc_needs_startup_cfg = 1, watchdog_timeout = 0;
   logic watchdog_clear_instruction = 0, reset_instruction = 0, stack_overflow = 0;
   logic stack_underflow = 0, programming_exit = 0, interrupt_wake = 0;
   logic global_interrupt_enable = 1, brownout_trip, low_power_supply_monitor_trip;
   logic oscillator_startup_done, brownout_enable_o, core_reset_n_o, vector_load_o;
   logic push_return_o, external_reset_pin_i, external_reset_pin_o, external_reset_pin_oe;
   logic pin_pullup_en_o, pin_gpio_value_o;
   logic [15:0] vector_o;
   logic [2:0]  reg_addr = 0;
   logic [7:0]  reg_wdata = 0, reg_rdata, v;
   int mismatches = 0, checks = 0, cycles = 0, n;
   always #5 clk = ~clk;
   rssc_top #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER), .FILT_LEN(4)) u_dut (.*);
   rssc_far_model u_far (.clk(clk), .rst_n(rst_n), .hold_low(hold_low), .sag(sag),
      .lp_sag(lp_sag), .pin_o(external_reset_pin_o), .pin_oe(external_reset_pin_oe),
      .pin(external_reset_pin_i), .trip(brownout_trip),
      .lp_trip(low_power_supply_monitor_trip), .osc_done(oscillator_startup_done));
   // ==========================================================
   // Shared tasks
   task check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 0;
   endtask
   task rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 0;
      @(negedge clk);
      check(16'(reg_rdata), 16'(exp));
   endtask
   // Bounded wait: a hung sequencer falls through to the vector check
   task wait_run;
      n = 0;
      @(negedge clk);
      while (core_reset_n_o !== 1'b1 && n < 500) begin
         @(negedge clk);
         n++;
      end
      check({vector_load_o, vector_o[14:0]}, 16'h8000);
   endtask
   task settle_reset;
      repeat (2) @(negedge clk);
      check(16'(core_reset_n_o), 16'h0000);
      wait_run();
   endtask
   // ==========================================================
   // Scenarios
   task t_power_on;
      wait_run();
      check(16'(n >= POWERUP_DELAY_TIMER + 10), 16'h0001);
      rd(REG_CAUSE, 8'h1C);
      rd(REG_STATUS, 8'h18);
      rd(REG_BOR_CTL, 8'h81);
      rd(3'h5, 8'h00);
      $display("power-on done");
   endtask
   task t_pin;
      @(posedge clk) hold_low <= 1;
      @(posedge clk) hold_low <= 0;
      repeat (10) @(negedge clk);
      check(16'(core_reset_n_o), 16'h0001);
      @(posedge clk) hold_low <= 1;
      repeat (12) @(negedge clk);
      check(16'({core_reset_n_o, external_reset_pin_oe, external_reset_pin_o}), 16'h0000);
      @(posedge clk) hold_low <= 0;
      wait_run();
      check(16'(n >= 10), 16'h0001);
      rd(REG_CAUSE, 8'h14);
      @(posedge clk) reset_pin_enable_cfg <= 0;
      hold_low <= 1;
      repeat (12) @(negedge clk);
      check(16'({core_reset_n_o, pin_gpio_value_o}), 16'h0002);
      wr(REG_PIN_CTL, 8'h00);
      rd(REG_PIN_CTL, 8'h00);
      check(16'(pin_pullup_en_o), 16'h0000);
      @(posedge clk) low_voltage_programming_cfg <= 1;
      repeat (12) @(negedge clk);
      check(16'(core_reset_n_o), 16'h0000);
      @(posedge clk) hold_low <= 0;
      wait_run();
      $display("pin done");
   endtask
   task t_flags;
      wr(REG_CAUSE, 8'hFF);
      rd(REG_CAUSE, 8'hDF);
      check(16'(core_reset_n_o), 16'h0001);
      wr(REG_CAUSE, 8'h1F);
      @(posedge clk) reset_instruction <= 1;
      @(posedge clk) reset_instruction <= 0;
      settle_reset();
      @(posedge clk) stack_overflow <= 1;
      @(posedge clk) stack_overflow <= 0;
      repeat (3) @(negedge clk);
      check(16'(core_reset_n_o), 16'h0001);
      @(posedge clk) stack_reset_enable_cfg <= 1;
      stack_underflow <= 1;
      stack_overflow <= 1;
      @(posedge clk) stack_underflow <= 0;
      stack_overflow <= 0;
      settle_reset();
      rd(REG_CAUSE, 8'hDB);
      @(posedge clk) programming_exit <= 1;
      @(posedge clk) programming_exit <= 0;
      settle_reset();
      $display("flags done");
   endtask
   task t_brownout;
      @(posedge clk) lp_sag <= 1;
      repeat (6) @(negedge clk);
      check(16'(core_reset_n_o), 16'h0000);
      @(posedge clk) lp_sag <= 0;
      wait_run();
      check(16'(n >= POWERUP_DELAY_TIMER + 10), 16'h0001);
      rd(REG_CAUSE, 8'h1E);
      @(posedge clk) supply_monitor_mode_field <= MODE_SW;
      wr(REG_BOR_CTL, 8'h00);
      @(posedge clk) sag <= 1;
      repeat (4) @(negedge clk);
      check(16'({core_reset_n_o, brownout_enable_o}), 16'h0002);
      @(posedge clk) sag <= 0;
      @(posedge clk) watchdog_timeout <= 1;
      @(posedge clk) watchdog_timeout <= 0;
      settle_reset();
      rd(REG_CAUSE, 8'h0E);
      rd(REG_STATUS, 8'h08);
      // Low-power trip in on-except-sleep mode re-arms the full power-on path
      @(posedge clk) supply_monitor_mode_field <= MODE_NOSLEEP;
      lp_sag <= 1;
      repeat (6) @(negedge clk);
      check(16'(core_reset_n_o), 16'h0000);
      @(posedge clk) lp_sag <= 0;
      wait_run();
      check(16'(n >= POWERUP_DELAY_TIMER + 10), 16'h0001);
      rd(REG_CAUSE, 8'h1C);
      rd(REG_STATUS, 8'h18);
      $display("brown-out done");
   endtask
   task t_wake;
      @(posedge clk) sleep_active <= 1;
      @(posedge clk) interrupt_wake <= 1;
      @(posedge clk) interrupt_wake <= 0;
      for (n = 0; n < 3 && vector_load_o !== 1'b1; n++) @(negedge clk);
      check(16'({push_return_o, vector_o[14:0]}), 16'h8004);
      @(posedge clk) sleep_active <= 0;
      $display("wake done");
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         print_verdict();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1;
      t_power_on();
      t_pin();
      t_flags();
      t_brownout();
      t_wake();
      print_verdict();
   end
endmodule // reset_source_and_startup_control_test
